/* verilog/tone_pkg.sv */
package tone_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] ADDR_TEMPO    = 8'h00;
  localparam logic [7:0] ADDR_DURATION = 8'h04;
  localparam logic [7:0] ADDR_PITCH    = 8'h08;
  localparam logic [7:0] ADDR_CONTROL  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;

  // Field positions in control and status words
  localparam int CTRL_RUN_BIT    = 0;
  localparam int CTRL_BUZZER_BIT = 1;
  localparam int STAT_MELODY_BIT = 0;
  localparam int STAT_BUZZ_BIT   = 1;
  localparam int STAT_REST_BIT   = 2;

  // Field widths
  localparam int TEMPO_W = 4;
  localparam int DUR_W   = 6;
  localparam int PITCH_W = 7;
  localparam int CNT_W   = 8;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Time base: tone reference and one note unit of 1.953125 ms
  localparam int     CLK_HZ_DEFAULT  = 200000000;
  localparam int     TONE_BASE_HZ    = 65536;
  localparam longint NOTE_UNIT_NS    = 1953125;
  localparam longint NS_PER_S        = 1000000000;
  localparam int     UNIT_BASE_TICKS =
    int'((NOTE_UNIT_NS * TONE_BASE_HZ) / NS_PER_S);

  // Buzzer: period step in base ticks, gate window in note units
  localparam logic [CNT_W-1:0] BUZZ_STEP_TICKS = 8'h10;
  localparam int               BUZZ_GATE_SHIFT = 5;

  // Software visible configuration
  typedef struct packed {
    logic [TEMPO_W-1:0] tempo;
    logic [DUR_W-1:0]   duration;
    logic [PITCH_W-1:0] pitch;
    logic               buzzer_select;
    logic               tone_run;
  } tone_cfg_t;

  localparam tone_cfg_t CFG_RESET = '0;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_MELODY = 2'b01,
    ST_BUZZ   = 2'b10
  } tone_state_t;

endpackage : tone_pkg

/* verilog/tone_timebase.sv */
`timescale 1ns/1ps
module tone_timebase
  import tone_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEFAULT
) (
  input  wire logic core_clk_in,
  input  wire logic srst_in,
  input  wire logic clear_in,
  output logic      base_tick_out,
  output logic      unit_tick_out
);

  if (CLK_HZ < 2 * TONE_BASE_HZ)
  begin : g_bad_clk
    $error("tone_timebase: CLK_HZ too low for the tone reference");
  end

  logic [31:0] acc_q, acc_d;
  logic [6:0]  div_q, div_d;
  logic        base_q, base_d;
  logic        unit_q, unit_d;
  logic [31:0] acc_sum;

  // Fractional accumulator: exact 65536 Hz on average, jitter one cycle
  always_comb
  begin
    acc_sum = acc_q + 32'(TONE_BASE_HZ);
    acc_d   = acc_sum;
    base_d  = 1'b0;
    div_d   = div_q;
    unit_d  = 1'b0;
    if (acc_sum >= 32'(CLK_HZ))
    begin
      acc_d  = acc_sum - 32'(CLK_HZ);
      base_d = 1'b1;
      if (div_q == 7'(UNIT_BASE_TICKS - 1))
      begin
        div_d  = '0;
        unit_d = 1'b1;
      end
      else
        div_d = div_q + 7'h01;
    end
    if (clear_in)
    begin
      acc_d  = '0;
      div_d  = '0;
      base_d = 1'b0;
      unit_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      acc_q  <= '0;
      div_q  <= '0;
      base_q <= 1'b0;
      unit_q <= 1'b0;
    end
    else
    begin
      acc_q  <= acc_d;
      div_q  <= div_d;
      base_q <= base_d;
      unit_q <= unit_d;
    end
  end

  assign base_tick_out = base_q;
  assign unit_tick_out = unit_q;

endmodule : tone_timebase

/* verilog/tone_period_counter.sv */
`timescale 1ns/1ps
module tone_period_counter
  import tone_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input  wire logic             core_clk_in,
  input  wire logic             srst_in,
  input  wire logic             clear_in,
  input  wire logic             tick_in,
  input  wire logic [WIDTH-1:0] last_in,
  output logic      [WIDTH-1:0] count_out
);

  if (WIDTH < 2)
  begin : g_bad_width
    $error("tone_period_counter: WIDTH must be at least 2");
  end

  logic [WIDTH-1:0] cnt_q, cnt_d;

  // Wraps at last_in; >= guards a period shortened mid-cycle
  always_comb
  begin
    cnt_d = cnt_q;
    if (clear_in)
      cnt_d = '0;
    else if (tick_in)
    begin
      if (cnt_q >= last_in)
        cnt_d = '0;
      else
        cnt_d = cnt_q + WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign count_out = cnt_q;

endmodule : tone_period_counter

/* verilog/tone_driver.sv */
`timescale 1ns/1ps
// Behaviour
// - Tempo value is the 4-bit tempo field, bits weighted 8,4,2,1.
// - Tempo value zero times exactly like tempo value one.
// - Duration value is the 6-bit duration field, weights 32 down to 1.
// - Duration value zero lasts exactly as long as value one.
// - Note or rest lasts 1.953125 ms times (tempo+1) times (duration+1).
// - Melody frequency is 65536 Hz over (pitch+1), pitch 4 to 127.
// - Pitch value is the 7-bit pitch field, weights 64 down to 1.
// - Upper five pitch bits all zero gives a rest, no tone.
// - A rest lasts as long as a note of the same codes.
// - In buzzer mode the tempo register picks the buzzer output mode.
// - In buzzer mode the duration register picks the high duty.
// - In buzzer mode the pitch register picks the buzzer frequency.
// - Run set in buzzer mode drives the buzzer waveform until run clears; steadily only at tempo 0, else gated.
// - Melody start copies duration and pitch to buffers, starts, interrupts.
// - Clearing run stops output immediately.
// - Buzzer uses low three pitch bits: 4.096 kHz down to 293 Hz.
// - Buzzer duty in sixteenths, minimum one; eighths at 4.096 kHz.
module tone_driver
  import tone_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEFAULT
) (
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic [31:0]      hrdata_out,
  output logic             hresp_out,
  output logic             tone_out_pin_out,
  output logic             tone_irq_out
);

  // Buzzer period in base ticks minus one: 16 at code 0, else 32 times
  // the code, so the top frequency is divided by 1, 2, 4, 6 ... 14
  function automatic logic [CNT_W-1:0] buzz_last(input logic [2:0] sel);
    if (sel == 3'h0)
      buzz_last = BUZZ_STEP_TICKS - 8'h01;
    else
      buzz_last = ({5'h00, sel} * (BUZZ_STEP_TICKS << 1)) - 8'h01;
  endfunction : buzz_last

  // High time in base ticks for the buzzer duty code
  function automatic logic [CNT_W-1:0] buzz_high(input logic [2:0] sel,
                                                 input logic [3:0] d);
    logic [3:0] e;
    e = 4'h0;
    if (sel == 3'h0)
    begin
      e = {1'b0, d[3:1]};
      if (e == 4'h0)
        e = 4'h1;
      buzz_high = {3'h0, e, 1'b0};
    end
    else
    begin
      e = (d == 4'h0) ? 4'h1 : d;
      buzz_high = {4'h0, e} * {4'h0, sel, 1'b0}; // Sixteenths of 32*sel
    end
  endfunction : buzz_high

  tone_cfg_t   cfg_q, cfg_d;
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ready_q;
  logic        take;

  tone_state_t       state_q, state_d;
  logic [DUR_W-1:0]  dur_buf_q, dur_buf_d;
  logic [PITCH_W-1:0] pitch_buf_q, pitch_buf_d;
  logic [TEMPO_W-1:0] tp_cnt_q, tp_cnt_d;
  logic [DUR_W-1:0]  dur_cnt_q, dur_cnt_d;
  logic [8:0]        gate_cnt_q, gate_cnt_d;
  logic              gate_on_q, gate_on_d;
  logic              irq_q, irq_d;
  logic              pin_q, pin_d;

  logic [TEMPO_W-1:0] tp_eff;
  logic [DUR_W-1:0]   ln_eff;
  logic               beat, note_end, resting, start, reload;
  logic               tb_clear, per_clear;
  logic               base_tick, unit_tick;
  logic [CNT_W-1:0]   per_last, per_cnt, half;
  logic [8:0]         gate_len;
  logic [2:0]         status;

  tone_timebase #(
    .CLK_HZ        (CLK_HZ)
  ) u_timebase (
    .core_clk_in   (core_clk_in),
    .srst_in       (srst_in),
    .clear_in      (tb_clear),
    .base_tick_out (base_tick),
    .unit_tick_out (unit_tick)
  );

  tone_period_counter #(
    .WIDTH       (CNT_W)
  ) u_period (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .clear_in    (per_clear),
    .tick_in     (base_tick),
    .last_in     (per_last),
    .count_out   (per_cnt)
  );

  // Bus slave: zero wait states; read mux uses next values so that a
  // read right behind a write returns the new data
  always_comb
  begin
    take      = hsel_in && hready_in && htrans_in[1];
    wr_pend_d = take && hwrite_in && (hsize_in == HSIZE_WORD);
    wr_addr_d = haddr_in[7:0];
    cfg_d     = cfg_q;
    if (wr_pend_q)
    begin
      case (wr_addr_q)
        ADDR_TEMPO:    cfg_d.tempo    = hwdata_in[TEMPO_W-1:0];
        ADDR_DURATION: cfg_d.duration = hwdata_in[DUR_W-1:0];
        ADDR_PITCH:    cfg_d.pitch    = hwdata_in[PITCH_W-1:0];
        ADDR_CONTROL:
        begin
          cfg_d.tone_run      = hwdata_in[CTRL_RUN_BIT];
          cfg_d.buzzer_select = hwdata_in[CTRL_BUZZER_BIT];
        end
        default: cfg_d = cfg_q;
      endcase
    end
    rdata_d = 32'h0000_0000;
    if (take && !hwrite_in)
    begin
      case (haddr_in[7:0])
        ADDR_TEMPO:    rdata_d = 32'(cfg_d.tempo);
        ADDR_DURATION: rdata_d = 32'(cfg_d.duration);
        ADDR_PITCH:    rdata_d = 32'(cfg_d.pitch);
        ADDR_CONTROL:  rdata_d = 32'({cfg_d.buzzer_select, cfg_d.tone_run});
        ADDR_STATUS:   rdata_d = 32'(status);
        default:       rdata_d = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      cfg_q     <= CFG_RESET;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
      ready_q   <= 1'b0;
    end
    else
    begin
      cfg_q     <= cfg_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
      ready_q   <= 1'b1;
    end
  end

  // Timing and tone decode
  always_comb
  begin
    status                  = 3'h0;
    status[STAT_MELODY_BIT] = (state_q == ST_MELODY);
    status[STAT_BUZZ_BIT]   = (state_q == ST_BUZZ);
    tp_eff   = (cfg_q.tempo == 4'h0) ? 4'h1 : cfg_q.tempo;
    ln_eff   = (dur_buf_q == 6'h00) ? 6'h01 : dur_buf_q;
    beat     = unit_tick && (tp_cnt_q >= tp_eff);
    note_end = beat && (dur_cnt_q >= ln_eff);
    resting  = (pitch_buf_q[PITCH_W-1:2] == 5'h00);
    status[STAT_REST_BIT] = (state_q == ST_MELODY) && resting;
    half     = ({1'b0, pitch_buf_q} + 8'h01) >> 1;
    per_last = (state_q == ST_BUZZ) ? buzz_last(cfg_q.pitch[2:0])
                                    : {1'b0, pitch_buf_q};
    gate_len = 9'(cfg_q.tempo) << BUZZ_GATE_SHIFT;
  end

  // Mode sequencing: run and buzzer select steer the machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (cfg_q.tone_run)
          state_d = cfg_q.buzzer_select ? ST_BUZZ : ST_MELODY;
      ST_MELODY, ST_BUZZ:
        if (!cfg_q.tone_run)
          state_d = ST_IDLE;
        else
          state_d = cfg_q.buzzer_select ? ST_BUZZ : ST_MELODY;
      default: state_d = ST_IDLE;
    endcase
    start  = (state_d == ST_MELODY) && (state_q != ST_MELODY);
    reload = start || ((state_q == ST_MELODY) && (state_d == ST_MELODY)
                       && note_end);
    tb_clear  = start || ((state_d == ST_BUZZ) && (state_q != ST_BUZZ));
    per_clear = tb_clear || reload;
  end

  // Note timing, buffers, gate and pin
  always_comb
  begin
    dur_buf_d   = dur_buf_q;
    pitch_buf_d = pitch_buf_q;
    tp_cnt_d    = tp_cnt_q;
    dur_cnt_d   = dur_cnt_q;
    gate_cnt_d  = gate_cnt_q;
    gate_on_d   = gate_on_q;
    irq_d       = 1'b0;
    if (reload)
    begin
      dur_buf_d   = cfg_q.duration;
      pitch_buf_d = cfg_q.pitch;
      tp_cnt_d    = '0;
      dur_cnt_d   = '0;
      irq_d       = 1'b1;
    end
    else if ((state_q == ST_MELODY) && unit_tick)
    begin
      tp_cnt_d = beat ? 4'h0 : tp_cnt_q + 4'h1;
      if (beat)
        dur_cnt_d = dur_cnt_q + 6'h01;
    end
    // Buzzer mode 0 sounds steadily; others gate in windows of tempo*32
    if ((state_q != ST_BUZZ) || (cfg_q.tempo == 4'h0))
    begin
      gate_cnt_d = '0;
      gate_on_d  = 1'b1;
    end
    else if (unit_tick)
    begin
      if (gate_cnt_q + 9'h001 >= gate_len)
      begin
        gate_cnt_d = '0;
        gate_on_d  = !gate_on_q;
      end
      else
        gate_cnt_d = gate_cnt_q + 9'h001;
    end
    case (state_q)
      ST_MELODY: pin_d = !resting && (per_cnt < half);
      ST_BUZZ:   pin_d = gate_on_q && (per_cnt <
                   buzz_high(cfg_q.pitch[2:0],
                             cfg_q.duration[3:0]));
      default:   pin_d = 1'b0;
    endcase
    if (state_d != state_q)
      pin_d = 1'b0;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      state_q     <= ST_IDLE;
      dur_buf_q   <= '0;
      pitch_buf_q <= '0;
      tp_cnt_q    <= '0;
      dur_cnt_q   <= '0;
      gate_cnt_q  <= '0;
      gate_on_q   <= 1'b1;
      irq_q       <= 1'b0;
      pin_q       <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      dur_buf_q   <= dur_buf_d;
      pitch_buf_q <= pitch_buf_d;
      tp_cnt_q    <= tp_cnt_d;
      dur_cnt_q   <= dur_cnt_d;
      gate_cnt_q  <= gate_cnt_d;
      gate_on_q   <= gate_on_d;
      irq_q       <= irq_d;
      pin_q       <= pin_d;
    end
  end

  assign hreadyout_out    = ready_q;
  assign hrdata_out       = rdata_q;
  assign hresp_out        = 1'b0;
  assign tone_out_pin_out = pin_q;
  assign tone_irq_out     = irq_q;

  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);

  a_start_copies: assert property (start |=> tone_irq_out
      && dur_buf_q == $past(cfg_q.duration) && pitch_buf_q == $past(cfg_q.pitch))
    else $error("melody start did not load buffers or interrupt");

  a_stop_quiet: assert property ($fell(cfg_q.tone_run) |=>
      !tone_out_pin_out && state_q == ST_IDLE)
    else $error("output not stopped after run cleared");

  a_rest_silent: assert property (
      state_q == ST_MELODY && resting |=> !tone_out_pin_out)
    else $error("pin toggled during a rest");

  a_tempo_floor: assert property (
      state_q == ST_MELODY && unit_tick && tp_cnt_q == 4'h0 |-> !beat)
    else $error("beat after a single unit");

  a_dur_bound: assert property (
      state_q == ST_MELODY |-> dur_cnt_q <= ln_eff)
    else $error("duration count beyond duration value");

  a_note_end_irq: assert property (note_end && state_d == ST_MELODY
      |=> tone_irq_out ##1 !tone_irq_out)
    else $error("note end without a single interrupt pulse");

  a_melody_period: assert property (
      state_q == ST_MELODY |-> per_last == {1'b0, pitch_buf_q}
                               && per_cnt <= {1'b0, pitch_buf_q})
    else $error("melody divider not at pitch value");

  a_buzz_period: assert property (state_q == ST_BUZZ |->
      per_last == ((cfg_q.pitch[2:0] == 3'h0) ? 8'h0F
                   : {cfg_q.pitch[2:0], 5'h00} - 8'h01))
    else $error("buzzer period wrong for frequency code");

  a_buzz_needs_run: assert property (
      state_q == ST_BUZZ |-> $past(cfg_q.tone_run && cfg_q.buzzer_select))
    else $error("buzzer active without run and select");

endmodule : tone_driver

/* verification/piezo_load.sv */
`timescale 1ns/1ps
module piezo_load (
  input  wire logic core_clk_in,
  input  wire logic pin_in,
  output int        period_out,
  output int        high_out,
  output int        rises_out
);
  logic last_q = 1'b0;
  int   cnt_q  = 0;
  int   hcnt_q = 0;

  // A speaker only reacts to edges; rise-to-rise gives the period
  always_ff @(posedge core_clk_in)
  begin
    last_q <= pin_in;
    cnt_q  <= (pin_in && !last_q) ? 1 : cnt_q + 1;
    hcnt_q <= pin_in ? ((!last_q) ? 1 : hcnt_q + 1) : 0;
    if (pin_in && !last_q)
    begin
      period_out <= cnt_q;
      rises_out  <= rises_out + 1;
    end
    if (!pin_in && last_q)
      high_out <= hcnt_q;
  end
endmodule : piezo_load

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import tone_pkg::*;
;
  localparam int SIM_HZ = 262144; // 4 clocks a base tick, 512 a unit

  logic        core_clk_in;
  logic        srst_in;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        pin;
  logic        irq;
  int          period;
  int          high;
  int          rises;
  int          n_errors;
  int          samples_checked;
  logic [31:0] seed;

  tone_driver #(.CLK_HZ(SIM_HZ)) dut (
    .core_clk_in      (core_clk_in),
    .srst_in          (srst_in),
    .hsel_in          (hsel),
    .haddr_in         (haddr),
    .htrans_in        (htrans),
    .hwrite_in        (hwrite),
    .hsize_in         (hsize),
    .hwdata_in        (hwdata),
    .hready_in        (hready),
    .hreadyout_out    (hready),
    .hrdata_out       (hrdata),
    .hresp_out        (hresp),
    .tone_out_pin_out (pin),
    .tone_irq_out     (irq)
  );

  piezo_load load (
    .core_clk_in (core_clk_in),
    .pin_in      (pin),
    .period_out  (period),
    .high_out    (high),
    .rises_out   (rises)
  );

  initial
  begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Note length in clocks, zero codes count as one
  function automatic int note_clks(int tp, int ln);
    return ((tp < 1 ? 1 : tp) + 1) * ((ln < 1 ? 1 : ln) + 1) * 512;
  endfunction : note_clks

  // Buzzer high time in clocks; the top frequency steps in eighths,
  // the others in sixteenths of a period of 32*n base ticks
  function automatic int buzz_high(int n, int d);
    if (n == 0)
      return 2 * ((d >> 1) < 1 ? 1 : (d >> 1)) * 4;
    return (d < 1 ? 1 : d) * 2 * n * 4;
  endfunction : buzz_high

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // Single word transfer; the address phase holds until ready is seen
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int k;
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    k = 0;
    do @(posedge core_clk_in); while (hready !== 1'b1 && ++k < 100);
    if (k >= 100)
      n_errors++;
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h00000000;
    k = 0;
    do @(posedge core_clk_in); while (hready !== 1'b1 && ++k < 100);
    rd = hrdata;
    if (k >= 100)
      n_errors++;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  // Cycles until the next interrupt pulse, bounded
  task automatic wait_irq(output int cyc);
    cyc = 0;
    do
    begin
      @(posedge core_clk_in);
      cyc++;
    end
    while (irq !== 1'b1 && cyc < 20000);
    if (cyc >= 20000)
      check(32'h00000000, 32'h00000001);
  endtask : wait_irq

  initial
  begin
    int          c;
    int          tp;
    int          ln;
    int          tn;
    int          r0;
    logic [31:0] rd;
    logic [7:0]  adr [4];
    logic [31:0] msk [4];
    adr = '{ADDR_TEMPO, ADDR_DURATION, ADDR_PITCH, 8'h14};
    msk = '{32'h0000000F, 32'h0000003F, 32'h0000007F, 32'h00000000};
    seed = 32'h000029C3;
    n_errors = 0;
    samples_checked = 0;
    srst_in = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h00000000;
    repeat (8) @(posedge core_clk_in);
    srst_in <= 1'b0;
    @(posedge core_clk_in);
    // Reset values, field widths, then an unmapped place
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, adr[i], 32'h0, rd);
      check(rd, 32'h00000000);
      check({31'h0, hresp}, 32'h00000000);
      wr(adr[i], 32'hFFFFFFFF);
      bus(1'b0, adr[i], 32'h0, rd);
      check(rd, msk[i]);
    end
    // Notes: timing between two note ends, pitch from the load
    for (int i = 0; i < 4; i++)
    begin
      tp = (i == 0) ? 0 : (i == 1) ? 1 : int'(rnd() % 3);
      ln = (i < 2) ? i : int'(rnd() % 3);
      tn = (i == 3) ? int'(rnd() % 4) : int'(rnd() % 124) + 4;
      wr(ADDR_TEMPO, tp);
      wr(ADDR_DURATION, ln);
      wr(ADDR_PITCH, tn);
      wr(ADDR_CONTROL, 32'h00000001);
      wait_irq(c);
      check(c < 8, 1'b1);
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      check(rd, (i == 3) ? 32'h00000005 : 32'h00000001);
      wait_irq(c);
      r0 = rises;
      wait_irq(c);
      check(c, note_clks(tp, ln));
      if (i == 3)
        check(rises - r0, 0);
      else
      begin
        check(period, (tn + 1) * 4);
        check(high, ((tn + 1) >> 1) * 4);
      end
      wr(ADDR_CONTROL, 32'h00000000);
      repeat (3) @(posedge core_clk_in);
      r0 = rises;
      repeat (600) @(posedge core_clk_in);
      check(pin, 1'b0);
      check(rises - r0, 0);
    end
    // Buzzer at every frequency, continuous, random duty except duty code 0 at frequency code 1
    for (int n = 0; n < 8; n++)
    begin
      tn = int'({25'h0, 4'(rnd()), 3'(n)});
      c = (n == 1) ? 0 : int'(rnd() % 16);
      wr(ADDR_TEMPO, 32'h00000000);
      wr(ADDR_DURATION, {26'h0, 2'(rnd()), 4'(c)});
      wr(ADDR_PITCH, tn);
      wr(ADDR_CONTROL, 32'h00000003);
      repeat ((n == 0) ? 256 : 512 * n) @(posedge core_clk_in);
      check(period, (n == 0) ? 64 : 128 * n);
      check(high, buzz_high(n, c));
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      check(rd, 32'h00000002);
      wr(ADDR_CONTROL, 32'h00000000);
    end
    // Gated buzzer mode 1: sounds for 32 units, then falls silent for the next 32
    wr(ADDR_TEMPO, 32'h00000001);
    wr(ADDR_PITCH, 32'h00000000);
    wr(ADDR_CONTROL, 32'h00000003);
    r0 = rises;
    repeat (16000) @(posedge core_clk_in);
    check(rises - r0 > 100, 1'b1);
    repeat (900) @(posedge core_clk_in);
    r0 = rises;
    repeat (2000) @(posedge core_clk_in);
    check(rises - r0, 0);
    wr(ADDR_CONTROL, 32'h00000000);
    summarize();
  end

  // Hang guard: well beyond the longest expected run
  initial
  begin
    repeat (90000) @(posedge core_clk_in);
    n_errors++;
    summarize();
  end
endmodule : tb_top
